// ===== verilog/nibble_cpu_pkg.sv
// Purpose: Shared constants for the nibble CPU transfer, table lookup and ALU block.
// Assumes: 9-bit instruction words, 4-bit data, 11-bit program counter.
// Notes:   The opcode bases have the low operand bits cleared.
package nibble_cpu_pkg;
  localparam int NIB_W   = 4;
  localparam int INSTR_W = 9;
  localparam int PC_W    = 11;
  localparam int FILE_W  = 2;
  localparam int PAGE_W  = 4;
  localparam int ROM_W   = 8;

  // Opcodes with their immediate field cleared.
  localparam logic [8:0] OP_XFER_TOGGLE = 9'h064;
  localparam logic [8:0] OP_XCHG_TOGGLE = 9'h060;
  localparam logic [8:0] OP_XCHG_DEC    = 9'h06c;
  localparam logic [8:0] OP_XCHG_INC    = 9'h068;
  localparam logic [8:0] OP_LOAD_IMM    = 9'h0b0;
  localparam logic [8:0] OP_TABLE_PAGE  = 9'h090;
  localparam logic [8:0] OP_ADD_MEM     = 9'h00a;
  localparam logic [8:0] OP_ADC_MEM     = 9'h00b;
  localparam logic [8:0] OP_ADD_IMM     = 9'h0a0;
  localparam logic [8:0] OP_SET_CARRY   = 9'h007;
  localparam logic [8:0] OP_CLR_CARRY   = 9'h006;
  localparam logic [8:0] OP_SKIP_CARRY0 = 9'h02f;
  localparam logic [8:0] OP_COMPLEMENT  = 9'h01c;
  localparam logic [8:0] OP_ROTATE_R    = 9'h01d;
  localparam logic [8:0] OP_LOGIC_SEL   = 9'h041;

  // Width of the immediate field per opcode group.
  localparam int IMM2_W = 2;
  localparam int IMM4_W = 4;

  // Logic operation select codes.
  localparam logic [1:0] LSEL_XOR = 2'h0;
  localparam logic [1:0] LSEL_OR  = 2'h1;
  localparam logic [1:0] LSEL_AND = 2'h2;

  // Reset values.
  localparam logic [3:0] NIB_RST   = 4'h0;
  localparam logic [1:0] FILE_RST  = 2'h0;
  localparam logic       CARRY_RST = 1'b0;

  // Wrap values of the digit pointer that cause a skip.
  localparam logic [3:0] Y_WRAP_DEC = 4'hf;
  localparam logic [3:0] Y_WRAP_INC = 4'h0;

  localparam int TABLE_CYCLES = 3;
endpackage : nibble_cpu_pkg

// ===== verilog/nibble_alu.sv
// Purpose: Combinational 4-bit adder and logic unit.
// Assumes: Operands arrive already selected by the caller.
// Notes:   No state is held here.
`timescale 1ns/1ns
module nibble_alu (
  // Operands
  input  wire logic [3:0] a,
  input  wire logic [3:0] operand,
  input  wire logic       cin,
  input  wire logic [1:0] lsel,
  // Results
  output logic      [3:0] sum,
  output logic            cout,
  output logic      [3:0] logic_res
);
  logic [4:0] total;

  always_comb begin
    total = {1'b0, a} + {1'b0, operand} + {4'h0, cin};
    sum   = total[3:0];
    cout  = total[4];
  end

  // Function chosen by the selection register; an unused code yields XOR.
  always_comb begin
    unique case (lsel)
      nibble_cpu_pkg::LSEL_OR:  logic_res = a | operand;
      nibble_cpu_pkg::LSEL_AND: logic_res = a & operand;
      default:                  logic_res = a ^ operand;
    endcase
  end
endmodule : nibble_alu

// ===== verilog/nibble_cpu_ram_alu_ops.sv
// Purpose: Executes transfer, exchange, table lookup, arithmetic, carry and logic instructions.
// Assumes: The sequencer offers one instruction per cycle and holds off while busy_q is high.
// Notes:   RAM writes are posted one cycle and bypassed to the next read of the same address.
// Notes on behaviour
// - Transfer with toggle loads the accumulator from RAM and XORs j into the file select.
// - Exchange with toggle swaps accumulator and RAM nibble and XORs j into the file select.
// - Exchange and decrement also decrements the digit pointer and skips when it becomes 15.
// - Exchange and increment also increments the digit pointer and skips when it becomes 0.
// - Table lookup takes three cycles, pushes the counter on the stack and forms the address.
// - Table lookup loads ROM bits 7..4 into B and 3..0 into the accumulator, then pops.
// - Add memory adds the addressed RAM nibble to the accumulator and keeps the 4-bit sum.
// - Add memory with carry adds RAM nibble and carry and stores sum and carry out.
// - Add immediate adds a 4-bit immediate to the accumulator.
// - The logic operation combines accumulator and port S by XOR, OR or AND per select.
// - Add immediate leaves the carry alone and skips when there is no overflow.
// - Set carry forces carry to one, clear carry to zero, accumulator unchanged.
// - Skip on carry zero skips the next instruction when the carry is zero.
// - Rotate right moves old carry into bit 3 and bit 0 into the carry.
`timescale 1ns/1ns
module nibble_cpu_ram_alu_ops #(
  parameter int STACK_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Instruction from the sequencer
  input  wire logic        instr_valid,
  input  wire logic [8:0]  instr,
  input  wire logic [10:0] pc_in,
  input  wire logic [2:0]  table_offset_high_bits,
  input  wire logic [1:0]  logic_select_op,
  // Port S pins
  input  wire logic [3:0]  port_s,
  // Data RAM
  input  wire logic [3:0]  ram_rdata,
  output logic      [5:0]  ram_addr_q,
  output logic             ram_we_q,
  output logic      [5:0]  ram_waddr_q,
  output logic      [3:0]  ram_wdata_q,
  // Program ROM
  input  wire logic [7:0]  rom_rdata,
  output logic      [10:0] rom_addr_q,
  // Sequencer feedback
  output logic             skip_q,
  output logic             busy_q,
  output logic             pc_load_q,
  output logic      [10:0] pc_value_q,
  // Architectural state
  output logic      [3:0]  acc_q,
  output logic      [3:0]  b_q,
  output logic             carry_flag_q,
  output logic      [1:0]  file_sel_q,
  output logic      [3:0]  data_pointer_q
);
  localparam int STACK_PTR_W = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_TAB_LOAD, ST_TAB_RET} tab_state_e;

  tab_state_e  state_q;
  logic [10:0] return_stack [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] stack_pointer_q;
  logic [3:0]  port_s_meta_q;
  logic [3:0]  port_s_q;
  logic [3:0]  mem_nib;
  logic [3:0]  alu_operand;
  logic        alu_cin;
  logic [3:0]  alu_sum;
  logic        alu_cout;
  logic [3:0]  alu_logic;
  logic [3:0]  y_dec;
  logic [3:0]  y_inc;
  logic        go;

  // True when the instruction matches a base with imm_w low operand bits.
  function automatic logic op_is(input logic [8:0] ins, input logic [8:0] base,
                                 input int imm_w);
    logic [8:0] mask;
    mask = 9'h1ff << imm_w;
    return (ins & mask) == base;
  endfunction : op_is

  assign go    = instr_valid && (state_q == ST_IDLE);
  assign y_dec = data_pointer_q - 4'h1;
  assign y_inc = data_pointer_q + 4'h1;

  // A posted write to the addressed cell is forwarded to the reader.
  assign mem_nib = (ram_we_q && ram_waddr_q == ram_addr_q) ? ram_wdata_q : ram_rdata;

  always_comb begin
    alu_operand = mem_nib;
    alu_cin     = 1'b0;
    if (op_is(instr, nibble_cpu_pkg::OP_ADD_IMM, nibble_cpu_pkg::IMM4_W)) begin
      alu_operand = instr[3:0];
    end else if (op_is(instr, nibble_cpu_pkg::OP_LOGIC_SEL, 0)) begin
      alu_operand = port_s_q;
    end else if (op_is(instr, nibble_cpu_pkg::OP_ADC_MEM, 0)) begin
      alu_cin = carry_flag_q;
    end
  end

  nibble_alu u_alu (
    .a         (acc_q),
    .operand   (alu_operand),
    .cin       (alu_cin),
    .lsel      (logic_select_op),
    .sum       (alu_sum),
    .cout      (alu_cout),
    .logic_res (alu_logic)
  );

  // Port S comes from pins and is synchronised before use.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      port_s_meta_q <= nibble_cpu_pkg::NIB_RST;
      port_s_q      <= nibble_cpu_pkg::NIB_RST;
    end else begin
      port_s_meta_q <= port_s;
      port_s_q      <= port_s_meta_q;
    end
  end

  // Accumulator and B.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= nibble_cpu_pkg::NIB_RST;
      b_q   <= nibble_cpu_pkg::NIB_RST;
    end else if (state_q == ST_TAB_LOAD) begin
      b_q   <= rom_rdata[7:4];
      acc_q <= rom_rdata[3:0];
    end else if (go) begin
      if (op_is(instr, nibble_cpu_pkg::OP_XFER_TOGGLE, nibble_cpu_pkg::IMM2_W) ||
          op_is(instr, nibble_cpu_pkg::OP_XCHG_TOGGLE, nibble_cpu_pkg::IMM2_W) ||
          op_is(instr, nibble_cpu_pkg::OP_XCHG_DEC, nibble_cpu_pkg::IMM2_W) ||
          op_is(instr, nibble_cpu_pkg::OP_XCHG_INC, nibble_cpu_pkg::IMM2_W)) begin
        acc_q <= mem_nib;
      end else if (op_is(instr, nibble_cpu_pkg::OP_LOAD_IMM, nibble_cpu_pkg::IMM4_W)) begin
        acc_q <= instr[3:0];
      end else if (op_is(instr, nibble_cpu_pkg::OP_ADD_MEM, 0) ||
                   op_is(instr, nibble_cpu_pkg::OP_ADC_MEM, 0) ||
                   op_is(instr, nibble_cpu_pkg::OP_ADD_IMM, nibble_cpu_pkg::IMM4_W)) begin
        acc_q <= alu_sum;
      end else if (op_is(instr, nibble_cpu_pkg::OP_LOGIC_SEL, 0)) begin
        acc_q <= alu_logic;
      end else if (op_is(instr, nibble_cpu_pkg::OP_COMPLEMENT, 0)) begin
        acc_q <= ~acc_q;
      end else if (op_is(instr, nibble_cpu_pkg::OP_ROTATE_R, 0)) begin
        acc_q <= {carry_flag_q, acc_q[3:1]};
      end
    end
  end

  // Carry flag; add immediate and plain add memory leave it alone.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      carry_flag_q <= nibble_cpu_pkg::CARRY_RST;
    end else if (go) begin
      if (op_is(instr, nibble_cpu_pkg::OP_ADC_MEM, 0)) begin
        carry_flag_q <= alu_cout;
      end else if (op_is(instr, nibble_cpu_pkg::OP_SET_CARRY, 0)) begin
        carry_flag_q <= 1'b1;
      end else if (op_is(instr, nibble_cpu_pkg::OP_CLR_CARRY, 0)) begin
        carry_flag_q <= 1'b0;
      end else if (op_is(instr, nibble_cpu_pkg::OP_ROTATE_R, 0)) begin
        carry_flag_q <= acc_q[0];
      end
    end
  end

  // File select and digit pointer, plus the posted RAM write of exchanges.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      file_sel_q     <= nibble_cpu_pkg::FILE_RST;
      data_pointer_q <= nibble_cpu_pkg::NIB_RST;
      ram_we_q       <= 1'b0;
      ram_waddr_q    <= 6'h00;
      ram_wdata_q    <= nibble_cpu_pkg::NIB_RST;
    end else begin
      ram_we_q <= 1'b0;
      if (go) begin
        if (op_is(instr, nibble_cpu_pkg::OP_XFER_TOGGLE, nibble_cpu_pkg::IMM2_W)) begin
          file_sel_q <= file_sel_q ^ instr[1:0];
        end else if (op_is(instr, nibble_cpu_pkg::OP_XCHG_TOGGLE, nibble_cpu_pkg::IMM2_W) ||
                     op_is(instr, nibble_cpu_pkg::OP_XCHG_DEC, nibble_cpu_pkg::IMM2_W) ||
                     op_is(instr, nibble_cpu_pkg::OP_XCHG_INC, nibble_cpu_pkg::IMM2_W)) begin
          file_sel_q  <= file_sel_q ^ instr[1:0];
          ram_we_q    <= 1'b1;
          ram_waddr_q <= ram_addr_q;
          ram_wdata_q <= acc_q;
          if (op_is(instr, nibble_cpu_pkg::OP_XCHG_DEC, nibble_cpu_pkg::IMM2_W)) begin
            data_pointer_q <= y_dec;
          end else if (op_is(instr, nibble_cpu_pkg::OP_XCHG_INC, nibble_cpu_pkg::IMM2_W)) begin
            data_pointer_q <= y_inc;
          end
        end
      end
    end
  end

  // RAM read address follows the file select and digit pointer.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ram_addr_q <= 6'h00;
    end else begin
      ram_addr_q <= {file_sel_q, data_pointer_q};
    end
  end

  // Skip request for the instruction that follows.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= 1'b0;
      if (go) begin
        if (op_is(instr, nibble_cpu_pkg::OP_XCHG_DEC, nibble_cpu_pkg::IMM2_W)) begin
          skip_q <= (y_dec == nibble_cpu_pkg::Y_WRAP_DEC);
        end else if (op_is(instr, nibble_cpu_pkg::OP_XCHG_INC, nibble_cpu_pkg::IMM2_W)) begin
          skip_q <= (y_inc == nibble_cpu_pkg::Y_WRAP_INC);
        end else if (op_is(instr, nibble_cpu_pkg::OP_ADD_IMM, nibble_cpu_pkg::IMM4_W)) begin
          skip_q <= !alu_cout;
        end else if (op_is(instr, nibble_cpu_pkg::OP_SKIP_CARRY0, 0)) begin
          skip_q <= !carry_flag_q;
        end
      end
    end
  end

  // Table lookup sequence: accept, load from ROM, return.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q         <= ST_IDLE;
      busy_q          <= 1'b0;
      stack_pointer_q <= '0;
      rom_addr_q      <= 11'h000;
      pc_load_q       <= 1'b0;
      pc_value_q      <= 11'h000;
    end else begin
      pc_load_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (go && op_is(instr, nibble_cpu_pkg::OP_TABLE_PAGE, nibble_cpu_pkg::IMM4_W)) begin
            stack_pointer_q <= stack_pointer_q + 1'b1;
            rom_addr_q      <= {instr[3:0], table_offset_high_bits, acc_q};
            busy_q          <= 1'b1;
            state_q         <= ST_TAB_LOAD;
          end
        end
        ST_TAB_LOAD: begin
          state_q <= ST_TAB_RET;
        end
        ST_TAB_RET: begin
          stack_pointer_q <= stack_pointer_q - 1'b1;
          pc_value_q      <= return_stack[stack_pointer_q - 1'b1];
          pc_load_q       <= 1'b1;
          busy_q          <= 1'b0;
          state_q         <= ST_IDLE;
        end
      endcase
    end
  end

  // Stack storage needs no reset; it is written before any read.
  always_ff @(posedge clk_sys) begin
    if (state_q == ST_IDLE && go &&
        op_is(instr, nibble_cpu_pkg::OP_TABLE_PAGE, nibble_cpu_pkg::IMM4_W)) begin
      return_stack[stack_pointer_q] <= pc_in;
    end
  end
endmodule : nibble_cpu_ram_alu_ops

// ===== verif/nibble_cpu_ram_alu_ops_assertions.sv
// Purpose: Concurrent checks on the ports of the nibble CPU ALU block.
// Assumes: One clock; an instruction is taken when valid and not busy.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ns
module nibble_cpu_ram_alu_ops_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Instruction
  input wire logic        instr_valid,
  input wire logic [8:0]  instr,
  input wire logic [10:0] pc_in,
  // Results
  input wire logic        skip_q,
  input wire logic        busy_q,
  input wire logic        pc_load_q,
  input wire logic [10:0] pc_value_q,
  input wire logic [3:0]  acc_q,
  input wire logic        carry_flag_q,
  input wire logic [3:0]  data_pointer_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic t;
  assign t = instr_valid && !busy_q;
  property p_load_imm;
    t && instr[8:4] == nibble_cpu_pkg::OP_LOAD_IMM[8:4] |=> acc_q == $past(instr[3:0]);
  endproperty
  property p_set_carry;
    t && instr == nibble_cpu_pkg::OP_SET_CARRY |=> carry_flag_q && $stable(acc_q);
  endproperty
  property p_clr_carry;
    t && instr == nibble_cpu_pkg::OP_CLR_CARRY |=> !carry_flag_q && $stable(acc_q);
  endproperty
  property p_complement;
    t && instr == nibble_cpu_pkg::OP_COMPLEMENT |=> acc_q == ~$past(acc_q)
      && $stable(carry_flag_q);
  endproperty
  property p_rotate;
    t && instr == nibble_cpu_pkg::OP_ROTATE_R |=> {acc_q, carry_flag_q}
      == {$past(carry_flag_q), $past(acc_q)};
  endproperty
  property p_add_imm;
    t && instr[8:4] == nibble_cpu_pkg::OP_ADD_IMM[8:4] |=> $stable(carry_flag_q)
      && acc_q == 4'($past(acc_q) + $past(instr[3:0]))
      && skip_q == ({1'b0, $past(acc_q)} + $past(instr[3:0]) < 5'h10);
  endproperty
  property p_skip_no_carry;
    t && instr == nibble_cpu_pkg::OP_SKIP_CARRY0 |=> skip_q == !$past(carry_flag_q);
  endproperty
  property p_xchg_dec;
    t && instr[8:2] == nibble_cpu_pkg::OP_XCHG_DEC[8:2] |=> skip_q == (data_pointer_q == 4'hf)
      && data_pointer_q == 4'($past(data_pointer_q) - 4'h1);
  endproperty
  property p_table;
    t && instr[8:4] == nibble_cpu_pkg::OP_TABLE_PAGE[8:4] |=> busy_q ##1 busy_q
      ##1 !busy_q && pc_load_q && pc_value_q == $past(pc_in, 3);
  endproperty
  a_load_imm: assert property (p_load_imm) else $error("load immediate wrong");
  a_set_carry: assert property (p_set_carry) else $error("set carry wrong");
  a_clr_carry: assert property (p_clr_carry) else $error("clear carry wrong");
  a_complement: assert property (p_complement) else $error("complement wrong");
  a_rotate: assert property (p_rotate) else $error("rotate wrong");
  a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");
  a_skip_no_carry: assert property (p_skip_no_carry) else $error("carry skip wrong");
  a_xchg_dec: assert property (p_xchg_dec) else $error("exchange decrement wrong");
  a_table: assert property (p_table) else $error("table lookup timing wrong");
  c_table: cover property (t && instr[8:4] == nibble_cpu_pkg::OP_TABLE_PAGE[8:4]);
  c_dec_skip: cover property (t && instr[8:2] == nibble_cpu_pkg::OP_XCHG_DEC[8:2] ##1 skip_q);
  c_add_skip: cover property (t && instr[8:4] == nibble_cpu_pkg::OP_ADD_IMM[8:4] ##1 skip_q);
endmodule : nibble_cpu_ram_alu_ops_assertions

// ===== verif/nibble_mem_model.sv
// Purpose: Data RAM and program ROM beside the block.
// Assumes: RAM reads combinationally and writes on the pulse edge.
// Notes:   ROM pattern is the low address byte XOR 8'h5a.
`timescale 1ns/1ns
module nibble_mem_model (
  // Clock
  input  wire logic        clk_sys,
  // RAM side
  input  wire logic [5:0]  ram_addr_q,
  input  wire logic        ram_we_q,
  input  wire logic [5:0]  ram_waddr_q,
  input  wire logic [3:0]  ram_wdata_q,
  output logic      [3:0]  ram_rdata,
  // ROM side
  input  wire logic [10:0] rom_addr_q,
  output logic      [7:0]  rom_rdata
);
  logic [3:0] mem [64];
  initial for (int i = 0; i < 64; i++) mem[i] = 4'(i * 7 + 3);
  always @(posedge clk_sys) if (ram_we_q) mem[ram_waddr_q] <= ram_wdata_q;
  assign ram_rdata = mem[ram_addr_q];
  assign rom_rdata = rom_addr_q[7:0] ^ 8'h5a;
endmodule : nibble_mem_model

// ===== verif/nibble_cpu_ram_alu_ops_tb.sv
// Purpose: Self-checking bench for the nibble CPU ALU block.
// Assumes: One instruction at a time with an idle cycle between.
// Notes:   Expected RAM values come from the memory model.
`timescale 1ns/1ns
module nibble_cpu_ram_alu_ops_tb;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic [8:0]  instr = 9'h000;
  logic [10:0] pc_in = 11'h000;
  logic [2:0]  table_offset_high_bits = 3'h0;
  logic [1:0]  logic_select_op = 2'h0;
  logic [3:0]  port_s = 4'h0;
  logic [3:0]  ram_rdata, acc_q, b_q, data_pointer_q, ram_wdata_q, m;
  logic [5:0]  ram_addr_q, ram_waddr_q;
  logic [7:0]  rom_rdata, r;
  logic [10:0] rom_addr_q, pc_value_q;
  logic [1:0]  file_sel_q;
  logic        ram_we_q, skip_q, busy_q, pc_load_q, carry_flag_q;
  int          mismatches = 0;
  int          checks = 0;
  nibble_cpu_ram_alu_ops uut (.clk_sys, .arst_n, .instr_valid, .instr, .pc_in,
    .table_offset_high_bits, .logic_select_op, .port_s, .ram_rdata, .ram_addr_q,
    .ram_we_q, .ram_waddr_q, .ram_wdata_q, .rom_rdata, .rom_addr_q, .skip_q, .busy_q,
    .pc_load_q, .pc_value_q, .acc_q, .b_q, .carry_flag_q, .file_sel_q, .data_pointer_q);
  nibble_mem_model u_mem (.clk_sys, .ram_addr_q, .ram_we_q, .ram_waddr_q, .ram_wdata_q,
    .ram_rdata, .rom_addr_q, .rom_rdata);
  always #20 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic run(input logic [8:0] i);
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b1;
    instr = i;
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
  endtask : run
  task automatic t_carry;
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h009);
    chk("acc", 4'h9, acc_q);
    run(nibble_cpu_pkg::OP_SET_CARRY);
    chk("carry", 1'b1, carry_flag_q);
    run(nibble_cpu_pkg::OP_SKIP_CARRY0);
    chk("skip", 1'b0, skip_q);
    run(nibble_cpu_pkg::OP_CLR_CARRY);
    chk("acc", 4'h9, acc_q);
    chk("carry", 1'b0, carry_flag_q);
    run(nibble_cpu_pkg::OP_SKIP_CARRY0);
    chk("skip", 1'b1, skip_q);
    run(nibble_cpu_pkg::OP_SET_CARRY);
    run(nibble_cpu_pkg::OP_ROTATE_R);
    chk("acc", 4'hc, acc_q);
    chk("carry", 1'b1, carry_flag_q);
    run(nibble_cpu_pkg::OP_ROTATE_R);
    chk("acc", 4'he, acc_q);
    chk("carry", 1'b0, carry_flag_q);
    run(nibble_cpu_pkg::OP_COMPLEMENT);
    chk("acc", 4'h1, acc_q);
    chk("carry", 1'b0, carry_flag_q);
  endtask : t_carry
  task automatic t_add_imm(input logic [3:0] a, input logic [3:0] n);
    run(nibble_cpu_pkg::OP_LOAD_IMM | {5'h00, a});
    run(nibble_cpu_pkg::OP_ADD_IMM | {5'h00, n});
    chk("acc", 4'(a + n), acc_q);
    chk("skip", {1'b0, a} + n < 5'h10, skip_q);
    chk("carry", 1'b0, carry_flag_q);
  endtask : t_add_imm
  task automatic t_add_mem;
    m = u_mem.mem[0];
    run(nibble_cpu_pkg::OP_SET_CARRY);
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h005);
    run(nibble_cpu_pkg::OP_ADD_MEM);
    chk("acc", 4'(m + 4'h5), acc_q);
    chk("carry", 1'b1, carry_flag_q);
    run(nibble_cpu_pkg::OP_CLR_CARRY);
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h00f);
    run(nibble_cpu_pkg::OP_ADC_MEM);
    chk("acc", 4'(m + 4'hf), acc_q);
    chk("carry", 1'b1, carry_flag_q);
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h000);
    run(nibble_cpu_pkg::OP_ADC_MEM);
    chk("acc", 4'(m + 4'h1), acc_q);
    chk("carry", 1'b0, carry_flag_q);
  endtask : t_add_mem
  task automatic t_xchg;
    run(nibble_cpu_pkg::OP_XFER_TOGGLE | 9'h002);
    chk("acc", m, acc_q);
    chk("file", 2'h2, file_sel_q);
    m = u_mem.mem[32];
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h00a);
    chk("raddr", 6'h20, ram_addr_q);
    run(nibble_cpu_pkg::OP_XCHG_TOGGLE | 9'h001);
    chk("acc", m, acc_q);
    chk("file", 2'h3, file_sel_q);
    chk("we", 1'b1, ram_we_q);
    chk("waddr", 6'h20, ram_waddr_q);
    chk("wdata", 4'ha, ram_wdata_q);
    run(nibble_cpu_pkg::OP_XCHG_DEC);
    chk("mem", 4'ha, u_mem.mem[32]);
    chk("digit", 4'hf, data_pointer_q);
    chk("skip", 1'b1, skip_q);
    run(nibble_cpu_pkg::OP_XCHG_INC);
    chk("skip", 1'b1, skip_q);
    run(nibble_cpu_pkg::OP_XCHG_INC);
    chk("digit", 4'h1, data_pointer_q);
    chk("skip", 1'b0, skip_q);
  endtask : t_xchg
  task automatic t_logic(input logic [1:0] s, input logic [3:0] e);
    port_s = 4'h6;
    logic_select_op = s;
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h00a);
    run(nibble_cpu_pkg::OP_LOGIC_SEL);
    chk("acc", e, acc_q);
  endtask : t_logic
  task automatic t_table;
    pc_in = 11'h2a5;
    table_offset_high_bits = 3'h5;
    r = 8'({4'h3, 3'h5, 4'hc}) ^ 8'h5a;
    run(nibble_cpu_pkg::OP_LOAD_IMM | 9'h00c);
    run(nibble_cpu_pkg::OP_TABLE_PAGE | 9'h003);
    chk("busy", 1'b1, busy_q);
    chk("rom", {4'h3, 3'h5, 4'hc}, rom_addr_q);
    @(posedge clk_sys);
    #1;
    chk("acc", r[3:0], acc_q);
    chk("b", r[7:4], b_q);
    @(posedge clk_sys);
    #1;
    chk("load", 1'b1, pc_load_q);
    chk("pc", 11'h2a5, pc_value_q);
  endtask : t_table
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    chk("acc", 4'h0, acc_q);
    chk("file", 2'h0, file_sel_q);
    t_carry;
    t_add_imm(4'h9, 4'h7);
    t_add_imm(4'h3, 4'h4);
    t_add_mem;
    t_xchg;
    t_logic(nibble_cpu_pkg::LSEL_XOR, 4'hc);
    t_logic(nibble_cpu_pkg::LSEL_OR, 4'he);
    t_logic(nibble_cpu_pkg::LSEL_AND, 4'h2);
    t_logic(2'h3, 4'hc);
    t_table;
    end_of_test;
  end
  initial begin
    #80000;
    mismatches++;
    end_of_test;
  end
endmodule : nibble_cpu_ram_alu_ops_tb
bind nibble_cpu_ram_alu_ops nibble_cpu_ram_alu_ops_assertions u_chk (.clk_sys, .arst_n,
  .instr_valid, .instr, .pc_in, .skip_q, .busy_q, .pc_load_q, .pc_value_q, .acc_q,
  .carry_flag_q, .data_pointer_q);
